/* hw/pcib_top.sv */
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module pcib_top (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pci initiator cycles
    output logic pci_req,
    output pcib_pkg::pcib_cmd_t pci_cmd,
    output logic [31:0] pci_addr,
    output logic [3:0] pci_be_n,
    output logic [31:0] pci_wdata,
    input wire logic pci_ack,
    input wire logic [31:0] pci_rdata,
    // header load into the pci core
    output logic core_ld_valid,
    output logic [1:0] core_ld_sel,
    output logic [31:0] core_ld_data,
    // dma channel
    output logic dma_start,
    output logic dma_xfer_req,
    output logic [31:2] dma_desc_addr,
    output logic [31:2] dma_gbus_addr,
    output logic [31:2] dma_pci_addr,
    input wire logic dma_word_ack
);
    import pcib_pkg::*;

    pcib_cyc_if cyc ();

    // register state
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic req_reg;
    logic [23:0] cfg_addr_reg;
    logic [2:0] ctrl_reg;
    logic [31:0] ident_reg;
    logic [31:0] class_reg;
    logic [31:0] subsys_reg;
    logic [31:0] misc_reg;
    logic ld_valid_reg;
    logic [1:0] ld_sel_reg;
    logic [31:0] ld_data_reg;
    logic [31:2] desc_reg;
    logic [31:2] gaddr_reg;
    logic [31:2] paddr_reg;
    logic [21:0] cnt_reg;
    logic start_reg;
    logic xfer_reg;

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign core_ld_valid = ld_valid_reg;
    assign core_ld_sel = ld_sel_reg;
    assign core_ld_data = ld_data_reg;
    assign dma_start = start_reg;
    assign dma_xfer_req = xfer_reg;
    assign dma_desc_addr = desc_reg;
    assign dma_gbus_addr = gaddr_reg;
    assign dma_pci_addr = paddr_reg;

    ////////////////////////////////////////////////////////////////////
    // address decode, word aligned
    wire hit_cfg_addr = paddr[15:2] == OFS_CFG_ADDR[15:2];
    wire hit_cfg_data = paddr[15:2] == OFS_CFG_DATA[15:2];
    wire hit_intack = paddr[15:2] == OFS_INTACK[15:2];
    wire hit_special = paddr[15:2] == OFS_SPECIAL[15:2];
    wire hit_ident = paddr[15:2] == OFS_HDR_IDENT[15:2];
    wire hit_class = paddr[15:2] == OFS_HDR_CLASS[15:2];
    wire hit_subsys = paddr[15:2] == OFS_HDR_SUBSYS[15:2];
    wire hit_misc = paddr[15:2] == OFS_HDR_MISC[15:2];
    wire hit_ctrl = paddr[15:2] == OFS_CTRL[15:2];
    wire hit_desc = paddr[15:2] == OFS_DMA_DESC[15:2];
    wire hit_gaddr = paddr[15:2] == OFS_DMA_GADDR[15:2];
    wire hit_paddr = paddr[15:2] == OFS_DMA_PADDR[15:2];
    wire hit_count = paddr[15:2] == OFS_DMA_COUNT[15:2];
    wire hit_hdr = hit_ident | hit_class | hit_subsys | hit_misc;
    wire hit_dma = hit_desc | hit_gaddr | hit_paddr | hit_count;
    wire hit_any = hit_cfg_addr | hit_cfg_data | hit_intack | hit_special
                 | hit_hdr | hit_ctrl | hit_dma;

    // access classification; narrow writes only reach the data port
    wire narrow_wr = pwrite & (pstrb != 4'hf);
    wire bad = ~hit_any
             | (narrow_wr & ~hit_cfg_data)
             | (hit_cfg_data & pwrite & (pstrb == 4'h0))
             | (hit_intack & pwrite)
             | (hit_special & ~pwrite);
    wire is_port = hit_cfg_data | hit_intack | hit_special;
    wire acc = psel & penable & ~pready_reg;
    wire wr_commit = psel & penable & pready_reg & pwrite & ~bad & ~is_port;

    ////////////////////////////////////////////////////////////////////
    // configuration cycle addressing and byte lanes
    wire big_end = ctrl_reg[CTRL_BIG_END_BIT];
    wire be_swap = ctrl_reg[CTRL_BE_SWAP_BIT];
    wire hdr_load = ctrl_reg[CTRL_HDR_LOAD_BIT];
    wire [3:0] strb_in = pwrite ? pstrb : 4'hf;
    wire [3:0] lanes = big_end ? pcib_rev4(strb_in) : strb_in;
    wire [1:0] off_lo = lanes[0] ? 2'd0 : lanes[1] ? 2'd1 : lanes[2] ? 2'd2 : 2'd3;
    wire [3:0] pci_lanes = be_swap ? pcib_rev4(lanes) : lanes;
    wire [4:0] dev_num = cfg_addr_reg[15:11];
    wire [20:0] idsel = (dev_num <= DEV_NUM_MAX) ? (21'h1 << dev_num) : 21'h0;
    // type 0 selects one upper line for device 0 to 20 and none above, type 1 passes the fields through
    wire [31:0] cfg_pci_addr = (cfg_addr_reg[1:0] == 2'b00)
                             ? {idsel, cfg_addr_reg[10:2], off_lo}
                             : {8'h00, cfg_addr_reg[23:2], off_lo};
    wire [31:0] cfg_wdata = big_end ? pcib_bswap(pwdata) : pwdata;
    wire [31:0] port_rdata = (hit_cfg_data & big_end) ? pcib_bswap(cyc.rdata) : cyc.rdata;

    // request toward the initiator; apb holds these during the wait
    assign cyc.req = req_reg;
    assign cyc.cmd = hit_cfg_data ? (pwrite ? PCIB_CMD_CFG_WR : PCIB_CMD_CFG_RD)
                   : hit_intack ? PCIB_CMD_INTACK
                   : PCIB_CMD_SPECIAL;
    assign cyc.addr = hit_cfg_data ? cfg_pci_addr : 32'h0;
    assign cyc.be_n = hit_cfg_data ? ~pci_lanes : 4'h0;
    assign cyc.wdata = hit_cfg_data ? cfg_wdata : pwdata;

    ////////////////////////////////////////////////////////////////////
    // register read mux; reserved bits read zero
    wire [31:0] rd_word = hit_cfg_addr ? {8'h00, cfg_addr_reg}
                        : hit_ident ? ident_reg
                        : hit_class ? class_reg
                        : hit_subsys ? subsys_reg
                        : hit_misc ? misc_reg
                        : hit_ctrl ? {29'h0, ctrl_reg}
                        : hit_desc ? {desc_reg, 2'b00}
                        : hit_gaddr ? {gaddr_reg, 2'b00}
                        : hit_paddr ? {paddr_reg, 2'b00}
                        : hit_count ? {8'h00, cnt_reg, 2'b00}
                        : 32'h0;

    // a port access that is not refused only completes with the pci cycle
    wire port_go = acc & is_port & ~bad;
    wire fin_now = acc & ((~is_port | bad) | cyc.done);
    wire [31:0] rd_next = (is_port & ~bad) ? port_rdata : rd_word;

    ////////////////////////////////////////////////////////////////////
    // apb answer and pci request handshake
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
            req_reg <= 1'b0;
        end else begin
            pready_reg <= fin_now;
            pslverr_reg <= fin_now & bad;
            prdata_reg <= (fin_now & ~pwrite) ? rd_next : 32'h0;
            req_reg <= cyc.done ? 1'b0 : (req_reg | port_go);
        end
    end

    pcib_init u_init (
        .mclk(mclk),
        .resetn(resetn),
        .cyc(cyc.initiator),
        .pci_req(pci_req),
        .pci_cmd(pci_cmd),
        .pci_addr(pci_addr),
        .pci_be_n(pci_be_n),
        .pci_wdata(pci_wdata),
        .pci_ack(pci_ack),
        .pci_rdata(pci_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // control, config address and header registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cfg_addr_reg <= RST_CFG_ADDR;
            ctrl_reg <= RST_CTRL;
            ident_reg <= RST_HDR_IDENT;
            class_reg <= {RST_CLASS_CODE, RST_REVISION};
            subsys_reg <= RST_HDR_SUBSYS;
            misc_reg <= RST_HDR_MISC;
        end else if (wr_commit) begin
            if (hit_cfg_addr) cfg_addr_reg <= pwdata[23:0];
            if (hit_ctrl) ctrl_reg <= pwdata[2:0];
            if (hit_ident) ident_reg <= pwdata;
            if (hit_class) class_reg <= pwdata;
            if (hit_subsys) subsys_reg <= pwdata;
            if (hit_misc) misc_reg <= pwdata;
        end
    end

    // header writes are forwarded to the core only while loading is on
    wire hdr_fwd = wr_commit & hit_hdr & hdr_load;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ld_valid_reg <= 1'b0;
            ld_sel_reg <= 2'b00;
            ld_data_reg <= 32'h0;
        end else begin
            ld_valid_reg <= hdr_fwd;
            if (hdr_fwd) begin
                ld_sel_reg <= paddr[3:2];
                ld_data_reg <= pwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // dma channel registers survive reset, so no reset branch here;
    // a software count write beats a same-cycle decrement
    wire cnt_wr = wr_commit & hit_count;
    wire cnt_dec = dma_word_ack & (cnt_reg != 22'h0);
    wire [21:0] cnt_next = cnt_wr ? pwdata[23:2]
                         : cnt_dec ? cnt_reg - 22'h1 : cnt_reg;
    wire start_cond = wr_commit & hit_desc & (pwdata[31:2] != 30'h0);

    always_ff @(posedge mclk) begin
        if (wr_commit & hit_desc) desc_reg <= pwdata[31:2];
        if (wr_commit & hit_gaddr) gaddr_reg <= pwdata[31:2];
        if (wr_commit & hit_paddr) paddr_reg <= pwdata[31:2];
        cnt_reg <= cnt_next;
    end

    // start pulse and data-move permission
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            start_reg <= 1'b0;
            xfer_reg <= 1'b0;
        end else begin
            start_reg <= start_cond;
            xfer_reg <= (start_cond | xfer_reg) & (cnt_next != 22'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_issue;
        $rose(req_reg);
    endsequence
    sequence s_finish;
        cyc.done ##1 pready_reg;
    endsequence

    property p_narrow_refused;
        psel && penable && pready_reg && pwrite && !hit_cfg_data && pstrb != 4'hf
            |-> pslverr_reg;
    endproperty
    a_narrow_refused: assert property (p_narrow_refused)
        else $error("narrow write to word register not refused");

    property p_type1_addr;
        s_issue and (hit_cfg_data && cfg_addr_reg[1:0] == 2'b01)
            |-> cyc.addr[31:2] == {8'h00, cfg_addr_reg[23:2]};
    endproperty
    a_type1_addr: assert property (p_type1_addr)
        else $error("type 1 config address wrong");

    property p_type0_idsel;
        s_issue and (hit_cfg_data && cfg_addr_reg[1:0] == 2'b00 && cfg_addr_reg[15:11] <= 5'h14)
            |-> $onehot(cyc.addr[31:11]) && (cyc.addr[31:11] >> cfg_addr_reg[15:11]) == 21'h1;
    endproperty
    a_type0_idsel: assert property (p_type0_idsel)
        else $error("type 0 target select line wrong");

    property p_big_mirror;
        s_issue and (hit_cfg_data && big_end && pwrite && pstrb == 4'h1)
            |-> cyc.addr[1:0] == 2'b11;
    endproperty
    a_big_mirror: assert property (p_big_mirror)
        else $error("big endian byte offset not mirrored");

    property p_be_swap;
        s_issue and (hit_cfg_data && be_swap && !big_end && pwrite && pstrb == 4'h1)
            |-> cyc.be_n == 4'b0111;
    endproperty
    a_be_swap: assert property (p_be_swap)
        else $error("byte enables not swapped");

    property p_cfg_cmd;
        s_issue and hit_cfg_data |-> cyc.cmd == (pwrite ? PCIB_CMD_CFG_WR : PCIB_CMD_CFG_RD);
    endproperty
    a_cfg_cmd: assert property (p_cfg_cmd)
        else $error("config port issued wrong cycle kind");

    property p_intack_data;
        acc && hit_intack && !pwrite && cyc.done
            |=> pready_reg && prdata_reg == $past(cyc.rdata);
    endproperty
    a_intack_data: assert property (p_intack_data)
        else $error("intack data not returned");

    property p_special_msg;
        s_issue and hit_special |-> cyc.cmd == PCIB_CMD_SPECIAL && cyc.wdata == pwdata;
    endproperty
    a_special_msg: assert property (p_special_msg)
        else $error("special cycle message wrong");

    property p_hdr_load;
        hdr_fwd |=> ld_valid_reg && ld_data_reg == $past(pwdata);
    endproperty
    a_hdr_load: assert property (p_hdr_load)
        else $error("header load not forwarded");

    property p_dma_start;
        wr_commit && hit_desc |=> start_reg == ($past(pwdata) >= 32'h4);
    endproperty
    a_dma_start: assert property (p_dma_start)
        else $error("descriptor write start wrong");

    property p_zero_count;
        xfer_reg |-> cnt_reg != 22'h0;
    endproperty
    a_zero_count: assert property (p_zero_count)
        else $error("transfer requested with zero count");

    property p_count_dec;
        cnt_dec && !cnt_wr |=> cnt_reg == $past(cnt_reg) - 22'h1;
    endproperty
    a_count_dec: assert property (p_count_dec)
        else $error("count not decremented");

    // the pci cycle needs at least three edges, so no early answer
    property p_port_wait;
        s_issue |-> !pready_reg [*3];
    endproperty
    a_port_wait: assert property (p_port_wait)
        else $error("port access answered too soon");

    property p_port_hold;
        req_reg && !cyc.done |=> !pready_reg;
    endproperty
    a_port_hold: assert property (p_port_hold)
        else $error("port access completed before pci cycle");
endmodule

/* hw/pcib_pkg.sv */
// How it works
// - only config data port takes narrow writes
// - config address high bits from address register
// - big endian mirrors config data lanes
// - optional byte enable swap for config cycles
// - data port read/write issues config read/write
// - intack port read returns acknowledge cycle data
// - special port write sends value as message
// - header writes load core when enabled
// - ident register holds device and vendor ids
// - class register holds class code, revision
// - subsystem register holds subsystem ids
// - misc register holds latency, grant, pin, type
// - descriptor pointer is word aligned address
// - non-zero descriptor write starts dma
// - dma registers have no reset
// - internal address feeds internal side
// - pci address feeds pci side
// - zero count moves no data
// - count shows bytes still to move, in whole words
// - address register holds bus, dev, fn, reg, type
// - type 0 decodes idsel, type 1 passes through
package pcib_pkg;
    // register byte offsets
    localparam logic [15:0] OFS_CFG_ADDR = 16'hd1a0;
    localparam logic [15:0] OFS_CFG_DATA = 16'hd1a4;
    localparam logic [15:0] OFS_INTACK = 16'hd1c8;
    localparam logic [15:0] OFS_SPECIAL = 16'hd1cc;
    localparam logic [15:0] OFS_HDR_IDENT = 16'hd1e0;
    localparam logic [15:0] OFS_HDR_CLASS = 16'hd1e4;
    localparam logic [15:0] OFS_HDR_SUBSYS = 16'hd1e8;
    localparam logic [15:0] OFS_HDR_MISC = 16'hd1ec;
    localparam logic [15:0] OFS_CTRL = 16'hd1f0;
    localparam logic [15:0] OFS_DMA_DESC = 16'hd200;
    localparam logic [15:0] OFS_DMA_GADDR = 16'hd204;
    localparam logic [15:0] OFS_DMA_PADDR = 16'hd208;
    localparam logic [15:0] OFS_DMA_COUNT = 16'hd20c;
    // control register bit positions
    localparam int CTRL_HDR_LOAD_BIT = 0;
    localparam int CTRL_BE_SWAP_BIT = 1;
    localparam int CTRL_BIG_END_BIT = 2;
    // reset values; identifier values are arbitrary
    localparam logic [23:0] RST_CFG_ADDR = 24'h00_0000;
    localparam logic [2:0] RST_CTRL = 3'h0;
    localparam logic [31:0] RST_HDR_IDENT = 32'h1234_5678;
    localparam logic [23:0] RST_CLASS_CODE = 24'h06_0000;
    localparam logic [7:0] RST_REVISION = 8'h01;
    localparam logic [31:0] RST_HDR_SUBSYS = 32'h0001_0001;
    localparam logic [31:0] RST_HDR_MISC = 32'h0000_0000;
    // type 0 idsel decode limit
    localparam logic [4:0] DEV_NUM_MAX = 5'h14;
    // pci cycle kinds handed to the initiator
    typedef enum logic [3:0] {
        PCIB_CMD_INTACK = 4'h0,
        PCIB_CMD_SPECIAL = 4'h1,
        PCIB_CMD_CFG_RD = 4'ha,
        PCIB_CMD_CFG_WR = 4'hb
    } pcib_cmd_t;

    // mirror the four byte lanes of a word
    function automatic logic [31:0] pcib_bswap(input logic [31:0] d);
        return {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction

    // mirror four lane enables
    function automatic logic [3:0] pcib_rev4(input logic [3:0] s);
        return {s[0], s[1], s[2], s[3]};
    endfunction
endpackage

/* hw/pcib_cyc_if.sv */
`timescale 1ns/1ps
// one pci cycle request from the register side to the initiator
interface pcib_cyc_if;
    import pcib_pkg::*;
    logic req;
    pcib_cmd_t cmd;
    logic [31:0] addr;
    logic [3:0] be_n;
    logic [31:0] wdata;
    logic done;
    logic [31:0] rdata;
    modport master (output req, cmd, addr, be_n, wdata, input done, rdata);
    modport initiator (input req, cmd, addr, be_n, wdata, output done, rdata);
endinterface

/* hw/pcib_init.sv */
`timescale 1ns/1ps
module pcib_init (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // request from register side
    pcib_cyc_if.initiator cyc,
    // pci cycle port
    output logic pci_req,
    output pcib_pkg::pcib_cmd_t pci_cmd,
    output logic [31:0] pci_addr,
    output logic [3:0] pci_be_n,
    output logic [31:0] pci_wdata,
    input wire logic pci_ack,
    input wire logic [31:0] pci_rdata
);
    import pcib_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b10
    } pcib_ist_t;

    pcib_ist_t state_reg;
    logic done_reg;
    logic [31:0] rdata_reg;

    assign cyc.done = done_reg;
    assign cyc.rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////
    // cycle sequencer; done pulses on the ack, then ST_DONE waits for req to drop so one access never
    // launches two pci cycles
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            done_reg <= 1'b0;
            rdata_reg <= 32'h0;
            pci_req <= 1'b0;
            pci_cmd <= PCIB_CMD_INTACK;
            pci_addr <= 32'h0;
            pci_be_n <= 4'hf;
            pci_wdata <= 32'h0;
        end else begin
            done_reg <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (cyc.req) begin
                        pci_req <= 1'b1;
                        pci_cmd <= cyc.cmd;
                        pci_addr <= cyc.addr;
                        pci_be_n <= cyc.be_n;
                        pci_wdata <= cyc.wdata;
                        state_reg <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (pci_ack) begin
                        pci_req <= 1'b0;
                        rdata_reg <= pci_rdata;
                        done_reg <= 1'b1;
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (!cyc.req) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // the pci cycle stays requested until the far end acknowledges
    property p_pci_req_held;
        @(posedge mclk) disable iff (!resetn)
        pci_req && !pci_ack |=> pci_req && $stable(pci_addr);
    endproperty
    a_pci_req_held: assert property (p_pci_req_held)
        else $error("pci request dropped before acknowledge");
endmodule

/* verification/pcib_pci_agent.sv */
`timescale 1ns/1ps
// far-end pci agent: finishes each requested cycle after lat idle cycles
module pcib_pci_agent (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // pci cycle port
    input wire logic pci_req,
    output logic pci_ack,
    output logic [31:0] pci_rdata,
    // reply control from the bench
    input wire logic [3:0] lat,
    input wire logic [31:0] rsp
);
    logic [3:0] wait_cnt;

    // one ack per request; read data toggles outside the ack cycle so stale data never matches
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pci_ack <= 1'b0;
            wait_cnt <= 4'h0;
            pci_rdata <= 32'h0;
        end else if (pci_req && !pci_ack && wait_cnt >= lat) begin
            pci_ack <= 1'b1;
            wait_cnt <= 4'h0;
            pci_rdata <= rsp;
        end else begin
            pci_ack <= 1'b0;
            wait_cnt <= (pci_req && !pci_ack) ? wait_cnt + 4'h1 : 4'h0;
            pci_rdata <= ~pci_rdata;
        end
    end
endmodule

/* verification/pcib_top_tb_top.sv */
`timescale 1ns/1ps
module pcib_top_tb_top;
    import pcib_pkg::*;
    localparam logic [31:0] RSP = 32'ha5c3_0f96;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic dma_word_ack = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [3:0] lat = 4'h0;
    logic [31:0] prdata, pci_addr, pci_wdata, pci_rdata, core_ld_data, rd, c_addr, c_wd, c_ld;
    logic pready, pslverr, pci_req, pci_ack, core_ld_valid, dma_start, dma_xfer_req, err;
    pcib_cmd_t pci_cmd, c_cmd;
    logic [3:0] pci_be_n, c_be;
    logic [1:0] core_ld_sel, c_sel;
    logic [31:2] dma_desc_addr, dma_gbus_addr, dma_pci_addr;
    int mismatches = 0;
    int samples_checked = 0;
    int cyc_n = 0;
    int ld_n = 0;
    int st_n = 0;

    always #12.5 mclk = ~mclk;

    pcib_top i_pcib_top (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pci_req(pci_req), .pci_cmd(pci_cmd),
        .pci_addr(pci_addr), .pci_be_n(pci_be_n), .pci_wdata(pci_wdata), .pci_ack(pci_ack),
        .pci_rdata(pci_rdata), .core_ld_valid(core_ld_valid), .core_ld_sel(core_ld_sel),
        .core_ld_data(core_ld_data), .dma_start(dma_start), .dma_xfer_req(dma_xfer_req),
        .dma_desc_addr(dma_desc_addr), .dma_gbus_addr(dma_gbus_addr),
        .dma_pci_addr(dma_pci_addr), .dma_word_ack(dma_word_ack));
    pcib_pci_agent i_pcib_pci_agent (.mclk(mclk), .resetn(resetn), .pci_req(pci_req),
        .pci_ack(pci_ack), .pci_rdata(pci_rdata), .lat(lat), .rsp(RSP));

    ////////////////////////////////////////////////////////////////////////////////
    // capture each finished pci cycle and count the one-cycle pulses
    always @(posedge mclk) begin
        if (pci_ack === 1'b1) begin
            cyc_n++;
            c_cmd = pci_cmd;
            c_addr = pci_addr;
            c_be = pci_be_n;
            c_wd = pci_wdata;
        end
        if (core_ld_valid === 1'b1) begin
            ld_n++;
            c_sel = core_ld_sel;
            c_ld = core_ld_data;
        end
        if (dma_start === 1'b1) st_n++;
    end

    task automatic test_done();
        $display("compares %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; waits for pready under a bound, never assumes a latency
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 200);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 200) begin
            mismatches++;
            test_done();
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic e);
        apb(1'b1, a, d, s);
        chk("pslverr", e, err);
    endtask

    task automatic rdc(input logic [15:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0, 4'h0);
        chk("pslverr", ee, err);
        if (!ee) chk($sformatf("read %h", a), e, rd);
    endtask

    task automatic pc(input pcib_cmd_t m, input logic [31:0] a, input logic [3:0] b,
                      input logic [31:0] d);
        chk("pci_cmd", m, c_cmd);
        chk("pci_addr", a, c_addr);
        chk("pci_be_n", b, c_be);
        if (m == PCIB_CMD_CFG_WR || m == PCIB_CMD_SPECIAL) chk("pci_wdata", d, c_wd);
    endtask

    task automatic rst();
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
    endtask

    task automatic ack1();
        @(posedge mclk);
        dma_word_ack <= 1'b1;
        @(posedge mclk);
        dma_word_ack <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst();
        // reset values, then refused accesses that must start no pci cycle
        rdc(OFS_HDR_IDENT, 32'h1234_5678, 1'b0);
        rdc(OFS_HDR_CLASS, 32'h0600_0001, 1'b0);
        rdc(OFS_HDR_SUBSYS, 32'h0001_0001, 1'b0);
        rdc(OFS_HDR_MISC, 32'h0, 1'b0);
        rdc(16'hd1fc, 32'h0, 1'b1);
        wr(OFS_HDR_MISC, 32'hffff_ffff, 4'h3, 1'b1);
        wr(OFS_INTACK, 32'h1, 4'hf, 1'b1);
        rdc(OFS_SPECIAL, 32'h0, 1'b1);
        chk("pci cycles", 32'h0, cyc_n);
        // type 0 read against a slow far end, then type 1 narrow write
        lat <= 4'h6;
        wr(OFS_CFG_ADDR, 32'h0012_1a14, 4'hf, 1'b0);
        rdc(OFS_CFG_DATA, RSP, 1'b0);
        pc(PCIB_CMD_CFG_RD, 32'h0000_4214, 4'h0, 32'h0);
        lat <= 4'h0;
        wr(OFS_CFG_ADDR, 32'h0012_1a15, 4'hf, 1'b0);
        wr(OFS_CFG_DATA, 32'h00ab_0000, 4'h4, 1'b0);
        pc(PCIB_CMD_CFG_WR, 32'h0012_1a16, 4'hb, 32'h00ab_0000);
        // big endian lanes mirror; the swap bit alone, with big endian off, reverses the enables too
        wr(OFS_CTRL, 32'h4, 4'hf, 1'b0);
        wr(OFS_CFG_DATA, 32'h0000_00cd, 4'h1, 1'b0);
        pc(PCIB_CMD_CFG_WR, 32'h0012_1a17, 4'h7, 32'hcd00_0000);
        rdc(OFS_CFG_DATA, 32'h960f_c3a5, 1'b0);
        wr(OFS_CTRL, 32'h2, 4'hf, 1'b0);
        wr(OFS_CFG_DATA, 32'h0000_00cd, 4'h1, 1'b0);
        chk("pci_be_n", 32'h7, c_be);
        // acknowledge and special cycles
        wr(OFS_CTRL, 32'h0, 4'hf, 1'b0);
        rdc(OFS_INTACK, RSP, 1'b0);
        pc(PCIB_CMD_INTACK, 32'h0, 4'h0, 32'h0);
        wr(OFS_SPECIAL, 32'h0000_0002, 4'hf, 1'b0);
        pc(PCIB_CMD_SPECIAL, 32'h0, 4'h0, 32'h0000_0002);
        // header writes load the core only while enabled
        wr(OFS_HDR_IDENT, 32'hbeef_0001, 4'hf, 1'b0);
        rdc(OFS_HDR_IDENT, 32'hbeef_0001, 1'b0);
        wr(OFS_CTRL, 32'h1, 4'hf, 1'b0);
        wr(OFS_HDR_CLASS, 32'h0c03_1002, 4'hf, 1'b0);
        repeat (3) @(posedge mclk);
        chk("load pulses", 32'h1, ld_n);
        chk("core_ld_sel", 32'h1, c_sel);
        chk("core_ld_data", 32'h0c03_1002, c_ld);
        // dma: zero count still pulses start but moves no data, then three words counted down
        wr(OFS_DMA_COUNT, 32'h0, 4'hf, 1'b0);
        wr(OFS_DMA_DESC, 32'h0000_1000, 4'hf, 1'b0);
        repeat (3) @(posedge mclk);
        chk("start pulses", 32'h1, st_n);
        chk("dma_xfer_req", 32'h0, dma_xfer_req);
        wr(OFS_DMA_COUNT, 32'h0000_000c, 4'hf, 1'b0);
        wr(OFS_DMA_GADDR, 32'h8000_0010, 4'hf, 1'b0);
        wr(OFS_DMA_PADDR, 32'h4000_0020, 4'hf, 1'b0);
        wr(OFS_DMA_DESC, 32'h0000_2000, 4'hf, 1'b0);
        repeat (3) @(posedge mclk);
        chk("dma_xfer_req", 32'h1, dma_xfer_req);
        chk("dma_desc_addr", 32'h0000_0800, dma_desc_addr);
        chk("dma_gbus_addr", 32'h2000_0004, dma_gbus_addr);
        chk("dma_pci_addr", 32'h1000_0008, dma_pci_addr);
        ack1();
        rdc(OFS_DMA_COUNT, 32'h8, 1'b0);
        ack1();
        ack1();
        repeat (3) @(posedge mclk);
        chk("dma_xfer_req", 32'h0, dma_xfer_req);
        wr(OFS_DMA_DESC, 32'h0, 4'hf, 1'b0);
        repeat (3) @(posedge mclk);
        chk("start pulses", 32'h2, st_n);
        // a reset in mid-run keeps the dma registers
        rst();
        rdc(OFS_DMA_GADDR, 32'h8000_0010, 1'b0);
        rdc(OFS_HDR_IDENT, 32'h1234_5678, 1'b0);
        test_done();
    end
endmodule
